// *** design/iabd_pkg.sv ***
/*
 Shared constants for the I/O base address decoder: address field layout,
 factory base setting, register offsets within the 32-location window,
 access attributes and the bus-cycle state encoding.
 Assumes a single 40 MHz clock and an asynchronous active-high reset.
*/
package iabd_pkg;

	// Address field layout
	localparam int          ADDR_W        = 10;
	localparam int          BASE_MSB      = 9;
	localparam int          BASE_LSB      = 5;
	localparam int          BASE_W        = 5;
	localparam int          OFS_W         = 5;
	localparam int          DATA_W        = 16;

	// Factory switch setting: A9 and A5 up, giving base 220 hex
	localparam logic [4:0]  FACTORY_SW    = 5'h11;
	// Switch codes with A9 and A8 both low are reserved
	localparam logic [1:0]  RSV_TOP       = 2'h0;

	// Register offsets inside the window
	localparam logic [4:0]  OFS_CTRL      = 5'h00;
	localparam logic [4:0]  OFS_STATUS    = 5'h02;
	localparam logic [4:0]  OFS_IRQ_SEL   = 5'h04;
	localparam logic [4:0]  OFS_DMA_SEL   = 5'h06;
	localparam logic [4:0]  OFS_STB_START = 5'h08;
	localparam logic [4:0]  OFS_STB_CLEAR = 5'h0A;
	localparam logic [4:0]  OFS_DATA_LO   = 5'h0C;

	// Reset values: interrupts and DMA disabled until programmed
	localparam logic [15:0] CTRL_RST      = 16'h0000;
	localparam logic [3:0]  IRQ_SEL_RST   = 4'h0;
	localparam logic [2:0]  DMA_SEL_RST   = 3'h0;
	localparam logic [3:0]  IRQ_SEL_MASK  = 4'hF;
	localparam logic [2:0]  DMA_SEL_MASK  = 3'h7;
	localparam logic [15:0] RD_IDLE       = 16'h0000;

	// Bus cycle tracking
	typedef enum logic [1:0] {
		IABD_IDLE  = 2'b00,
		IABD_READ  = 2'b01,
		IABD_WRITE = 2'b10
	} iabd_cyc_type;

endpackage : iabd_pkg

// *** design/iabd_sync.sv ***
/*
 Two-flop synchroniser, parameterised width.
 Assumes each bit is an independent slow level from outside the clock domain.
*/
`timescale 1ns/10ps
module iabd_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         reset,
	// Data
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : iabd_sync

// *** design/iabd_match.sv ***
/*
 Base address comparator: compares host A9..A5 with the switch code and flags
 a reserved switch setting.
 Assumes its inputs are already synchronous to the clock.
*/
`timescale 1ns/10ps
module iabd_match
	import iabd_pkg::*;
(
	// Address and switch
	input  wire logic [iabd_pkg::ADDR_W-1:0] addr,
	input  wire logic [iabd_pkg::BASE_W-1:0] sw,
	// Result
	output logic                             hit,
	output logic                             sw_reserved
);

	// A5..A9 only; A4..A0 never take part in board selection
	assign hit         = (addr[BASE_MSB:BASE_LSB] == sw);
	assign sw_reserved = (sw[BASE_W-1:BASE_W-2] == RSV_TOP);

endmodule : iabd_match

// *** design/iabd_decoder.sv ***
/*
 I/O base address decoder for a plug-in board on the AT I/O bus.
 Holds switch capture, cycle claim, register select, the storing registers,
 the status readback and the strobe registers.
 Assumes bus strobes are asynchronous pins, sampled through two flops, and
 that the host holds address and data stable across each strobe.
*/
// How it works
// - Claim only when A9..A5 equal switches.
// - Switch up is one, down zero.
// - A4..A0 pick one of 32 byte locations.
// - Factory base is 220, window 220-23F.
// - A9=A8=0 settings reserved; never claim.
// - Only I/O cycles, byte or word.
// - Fixed offsets, each read-only or write-only, except the clear strobe, which acts on read or write.
// - Storing control registers, readable status registers.
// - Strobe registers act on access only.
// - IRQ and DMA selects programmed, reset disabled.
// - Switches place window; decode picks register.
`timescale 1ns/10ps
module iabd_decoder
	import iabd_pkg::*;
(
	// Clock and reset
	input  wire logic                             clock,
	input  wire logic                             reset,
	// Host bus pins
	input  wire logic [iabd_pkg::ADDR_W-1:0]      bus_addr,
	input  wire logic                             bus_aen,
	input  wire logic                             bus_ior_n,
	input  wire logic                             bus_iow_n,
	input  wire logic                             bus_memr_n,
	input  wire logic                             bus_memw_n,
	input  wire logic                             bus_sbhe_n,
	input  wire logic [iabd_pkg::DATA_W-1:0]      bus_data_in,
	output logic      [iabd_pkg::DATA_W-1:0]      bus_data_out,
	output logic                                  bus_data_oe_n,
	output logic                                  bus_io16_n,
	// Base address switch, one bit per position, up is high
	input  wire logic [iabd_pkg::BASE_W-1:0]      base_sw,
	// Board side
	input  wire logic [iabd_pkg::DATA_W-1:0]      board_status,
	input  wire logic [iabd_pkg::DATA_W-1:0]      board_data,
	output logic      [iabd_pkg::DATA_W-1:0]      ctrl_value,
	output logic      [3:0]                       irq_select,
	output logic      [2:0]                       dma_select,
	output logic                                  start_pulse,
	output logic                                  clear_pulse,
	output logic                                  data_read_pulse,
	output logic                                  sw_reserved_flag
);

	// Synchronised pins
	logic [ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0] wdata_s;
	logic [BASE_W-1:0] sw_s;
	logic              aen_s;
	logic              ior_s;
	logic              iow_s;
	logic              memr_s;
	logic              memw_s;
	logic              sbhe_s;

	iabd_sync #(.W(ADDR_W)) u_sync_addr (
		.clock    (clock),
		.reset    (reset),
		.async_in (bus_addr),
		.sync_out (addr_s)
	);

	iabd_sync #(.W(DATA_W)) u_sync_data (
		.clock    (clock),
		.reset    (reset),
		.async_in (bus_data_in),
		.sync_out (wdata_s)
	);

	iabd_sync #(.W(BASE_W)) u_sync_sw (
		.clock    (clock),
		.reset    (reset),
		.async_in (base_sw),
		.sync_out (sw_s)
	);

	iabd_sync #(.W(6)) u_sync_ctl (
		.clock    (clock),
		.reset    (reset),
		.async_in ({bus_aen, ~bus_ior_n, ~bus_iow_n, ~bus_memr_n, ~bus_memw_n,
			~bus_sbhe_n}),
		.sync_out ({aen_s, ior_s, iow_s, memr_s, memw_s, sbhe_s})
	);

	// Switch code captured after reset release; changes while powered are ignored
	logic [BASE_W-1:0] sw_q;
	logic              sw_valid_q;
	logic [1:0]        sw_wait_q;

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			sw_q       <= FACTORY_SW;
			sw_valid_q <= 1'b0;
			sw_wait_q  <= '0;
		end
		else
		begin
			// Synchroniser is still full of reset zeros for two edges
			sw_wait_q <= {sw_wait_q[0], 1'b1};
			if (sw_wait_q[1] && !sw_valid_q)
			begin
				sw_q       <= sw_s;
				sw_valid_q <= 1'b1;
			end
		end
	end

	// Address compare
	logic hit;
	logic sw_reserved;

	iabd_match u_match (
		.addr        (addr_s),
		.sw          (sw_q),
		.hit         (hit),
		.sw_reserved (sw_reserved)
	);

	wire claim_ok = hit && sw_valid_q && !sw_reserved && !aen_s && !memr_s && !memw_s;

	wire [OFS_W-1:0] ofs     = addr_s[OFS_W-1:0];
	wire             odd     = ofs[0];
	wire [OFS_W-1:0] ofs_wrd = {ofs[OFS_W-1:1], 1'b0};

	function automatic logic sel(input logic [OFS_W-1:0] a, input logic [OFS_W-1:0] o);
		sel = (a == o);
	endfunction : sel

	wire sel_ctrl   = sel(ofs_wrd, OFS_CTRL);
	wire sel_status = sel(ofs_wrd, OFS_STATUS);
	wire sel_irq    = sel(ofs_wrd, OFS_IRQ_SEL);
	wire sel_dma    = sel(ofs_wrd, OFS_DMA_SEL);
	wire sel_start  = sel(ofs_wrd, OFS_STB_START);
	wire sel_clear  = sel(ofs_wrd, OFS_STB_CLEAR);
	wire sel_data   = sel(ofs_wrd, OFS_DATA_LO);
	wire rd_map     = sel_status || sel_data;
	wire wr_map     = sel_ctrl || sel_irq || sel_dma || sel_start || sel_clear;

	// Cycle tracking: one action per strobe, taken at its leading edge
	iabd_cyc_type cyc_q;
	iabd_cyc_type cyc_d;
	wire          rd_start = (cyc_q == IABD_IDLE) && ior_s && !iow_s && claim_ok;
	wire          wr_start = (cyc_q == IABD_IDLE) && iow_s && !ior_s && claim_ok;

	always_comb
	begin
		cyc_d = cyc_q;
		case (cyc_q)
			IABD_IDLE:
			begin
				if (rd_start)
					cyc_d = IABD_READ;
				else if (wr_start)
					cyc_d = IABD_WRITE;
			end
			IABD_READ:
			begin
				if (!ior_s)
					cyc_d = IABD_IDLE;
			end
			IABD_WRITE:
			begin
				if (!iow_s)
					cyc_d = IABD_IDLE;
			end
			default:
				cyc_d = IABD_IDLE;
		endcase
	end

	// Byte lanes: even address carries the low lane, SBHE asks for the high one
	wire lo_en = !odd;
	wire hi_en = odd || sbhe_s;

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] wd, input logic lo, input logic hi, input logic od);
		logic [DATA_W-1:0] r;
		r = old;
		if (lo)
			r[7:0] = wd[7:0];
		if (hi)
			r[15:8] = od ? wd[7:0] : wd[15:8];
		merge = r;
	endfunction : merge

	// Storing registers
	logic [DATA_W-1:0] ctrl_q;
	logic [3:0]        irq_q;
	logic [2:0]        dma_q;
	wire  [DATA_W-1:0] ctrl_d = merge(ctrl_q, wdata_s, lo_en, hi_en, odd);
	wire  [DATA_W-1:0] irq_w  = merge({12'h000, irq_q}, wdata_s, lo_en, hi_en, odd);
	wire  [DATA_W-1:0] dma_w  = merge({13'h0000, dma_q}, wdata_s, lo_en, hi_en, odd);

	// Read data; write-only, strobe and unmapped locations answer idle
	wire [DATA_W-1:0] rd_word = sel_status ? board_status :
		sel_data ? board_data : RD_IDLE;
	wire [DATA_W-1:0] rd_d    = odd ? {8'h00, rd_word[15:8]} : rd_word;

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			cyc_q <= IABD_IDLE;
		else
			cyc_q <= cyc_d;
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			ctrl_q <= CTRL_RST;
			irq_q  <= IRQ_SEL_RST;
			dma_q  <= DMA_SEL_RST;
		end
		else if (wr_start)
		begin
			if (sel_ctrl)
				ctrl_q <= ctrl_d;
			if (sel_irq)
				irq_q <= irq_w[3:0] & IRQ_SEL_MASK;
			if (sel_dma)
				dma_q <= dma_w[2:0] & DMA_SEL_MASK;
		end
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			start_pulse     <= 1'b0;
			clear_pulse     <= 1'b0;
			data_read_pulse <= 1'b0;
		end
		else
		begin
			start_pulse     <= wr_start && sel_start;
			clear_pulse     <= (wr_start && sel_clear) || (rd_start && sel_clear);
			data_read_pulse <= rd_start && sel_data;
		end
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			bus_data_out  <= RD_IDLE;
			bus_data_oe_n <= 1'b1;
			bus_io16_n    <= 1'b1;
		end
		else
		begin
			if (rd_start)
				bus_data_out <= rd_d;
			bus_data_oe_n <= !(cyc_d == IABD_READ);
			// Word-wide only for even, mapped locations within the window
			bus_io16_n    <= !(claim_ok && !odd && (rd_map || wr_map) && (ior_s || iow_s));
		end
	end

	// Outputs straight from flops
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			ctrl_value       <= CTRL_RST;
			irq_select       <= IRQ_SEL_RST;
			dma_select       <= DMA_SEL_RST;
			sw_reserved_flag <= 1'b0;
		end
		else
		begin
			ctrl_value       <= ctrl_q;
			irq_select       <= irq_q;
			dma_select       <= dma_q;
			sw_reserved_flag <= sw_valid_q && sw_reserved;
		end
	end

endmodule : iabd_decoder

// *** verification/iabd_decoder_props.sv ***
/*
 Port checker for the base address decoder.
 Assumes the switch input is steady while reset is released.
*/
`timescale 1ns/10ps
module iabd_decoder_props
	import iabd_pkg::*;
(
	// Clock and reset
	input wire logic              clock,
	input wire logic              reset,
	// Host side
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic              bus_aen,
	input wire logic              bus_ior_n,
	input wire logic              bus_iow_n,
	input wire logic              bus_memr_n,
	input wire logic              bus_memw_n,
	input wire logic              bus_data_oe_n,
	// Board side
	input wire logic [BASE_W-1:0] base_sw,
	input wire logic              start_pulse,
	input wire logic              sw_reserved_flag
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	sequence rd_claim;
		$fell(bus_data_oe_n);
	endsequence
	sequence rd_end;
		$rose(bus_ior_n);
	endsequence
	base_match_a: assert property (rd_claim |-> $past(bus_addr[9:5], 2) == base_sw)
		else $error("read claimed at a foreign base");
	dma_ignore_a: assert property (rd_claim |-> !$past(bus_aen, 2))
		else $error("read claimed during a dma cycle");
	mem_ignore_a: assert property (rd_claim |-> $past(bus_memr_n, 2) && $past(bus_memw_n, 2))
		else $error("read claimed beside a memory strobe");
	read_cause_a: assert property (rd_claim |-> !$past(bus_ior_n, 2))
		else $error("data driven without a read strobe");
	reserved_quiet_a: assert property (sw_reserved_flag |-> bus_data_oe_n)
		else $error("reserved base drives the data bus");
	reserved_flag_a: assert property (sw_reserved_flag |-> base_sw[4:3] == 2'h0)
		else $error("reserved flag on a valid base");
	read_release_a: assert property (rd_end |-> ##[1:4] bus_data_oe_n)
		else $error("data bus held after the read");
	start_once_a: assert property (start_pulse |=> !start_pulse)
		else $error("start pulse longer than one cycle");
	start_cause_a: assert property (start_pulse |-> !$past(bus_iow_n, 2)
		&& $past(bus_addr[4:0], 2) == OFS_STB_START)
		else $error("start pulse without its write");
endmodule : iabd_decoder_props
bind iabd_decoder iabd_decoder_props u_props (.clock(clock), .reset(reset), .bus_addr(bus_addr),
	.bus_aen(bus_aen), .bus_ior_n(bus_ior_n), .bus_iow_n(bus_iow_n), .bus_memr_n(bus_memr_n),
	.bus_memw_n(bus_memw_n), .bus_data_oe_n(bus_data_oe_n), .base_sw(base_sw),
	.start_pulse(start_pulse), .sw_reserved_flag(sw_reserved_flag));

// *** verification/iabd_host_model.sv ***
/*
 Host processor model: runs one bus cycle per call of io.
 Assumes the caller leaves the switch steady and keeps to one call at a time.
*/
`timescale 1ns/10ps
module iabd_host_model
	import iabd_pkg::*;
(
	// Clock
	input wire logic              clock,
	// Bus pins driven by the host
	output logic [ADDR_W-1:0]     bus_addr,
	output logic                  bus_aen,
	output logic                  bus_ior_n,
	output logic                  bus_iow_n,
	output logic                  bus_memr_n,
	output logic                  bus_memw_n,
	output logic                  bus_sbhe_n,
	output logic [DATA_W-1:0]     bus_data_in,
	// Bus pins driven by the board
	input wire logic [DATA_W-1:0] bus_data_out,
	input wire logic              bus_data_oe_n
);
	initial
	begin
		{bus_ior_n, bus_iow_n, bus_memr_n, bus_memw_n, bus_sbhe_n} = 5'h1F;
		bus_aen = 1'b0;
		bus_addr = '0;
		bus_data_in = '0;
	end
	task automatic io(input logic rd, input logic [9:0] a, input logic [15:0] d,
		input logic word, input logic aen, input logic mem,
		output logic [15:0] q, output logic oe_n);
		@(negedge clock);
		bus_addr = a;
		bus_aen = aen;
		bus_sbhe_n = !word;
		bus_data_in = d;
		{bus_memr_n, bus_memw_n} = {!(mem && rd), !(mem && !rd)};
		{bus_ior_n, bus_iow_n} = {!(!mem && rd), !(!mem && !rd)};
		repeat (6) @(posedge clock);
		@(negedge clock);
		q = bus_data_out;
		oe_n = bus_data_oe_n;
		{bus_ior_n, bus_iow_n, bus_memr_n, bus_memw_n} = 4'hF;
		// Stale write data is inverted so nothing can lean on it
		bus_data_in = ~d;
		repeat (3) @(negedge clock);
	endtask : io
endmodule : iabd_host_model

// *** verification/iabd_decoder_tb.sv ***
/*
 Testbench for the base address decoder with a host model in front.
 Assumes the switch is captured once after each reset release.
*/
`timescale 1ns/10ps
module iabd_decoder_tb;
	import iabd_pkg::*;
	logic clock, reset, aen, ior_n, iow_n, memr_n, memw_n, sbhe_n, oe_n, io16_n;
	logic start_p, clear_p, dread_p, rsv, ho;
	logic [9:0] addr;
	logic [4:0] sw;
	logic [15:0] din, dout, st, bd, ctrl, q;
	logic [3:0] irq;
	logic [2:0] dma;
	int n_errors, samples_checked, n_start, n_clear, n_dread, n_io16;
	iabd_decoder u_iabd_decoder (.clock(clock), .reset(reset), .bus_addr(addr), .bus_aen(aen),
		.bus_ior_n(ior_n), .bus_iow_n(iow_n), .bus_memr_n(memr_n), .bus_memw_n(memw_n),
		.bus_sbhe_n(sbhe_n), .bus_data_in(din), .bus_data_out(dout), .bus_data_oe_n(oe_n),
		.bus_io16_n(io16_n), .base_sw(sw), .board_status(st), .board_data(bd),
		.ctrl_value(ctrl), .irq_select(irq), .dma_select(dma), .start_pulse(start_p),
		.clear_pulse(clear_p), .data_read_pulse(dread_p), .sw_reserved_flag(rsv));
	iabd_host_model u_iabd_host_model (.clock(clock), .bus_addr(addr), .bus_aen(aen),
		.bus_ior_n(ior_n), .bus_iow_n(iow_n), .bus_memr_n(memr_n), .bus_memw_n(memw_n),
		.bus_sbhe_n(sbhe_n), .bus_data_in(din), .bus_data_out(dout), .bus_data_oe_n(oe_n));
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock)
	begin
		n_start += int'(start_p === 1'b1);
		n_clear += int'(clear_p === 1'b1);
		n_dread += int'(dread_p === 1'b1);
		n_io16 += int'(io16_n === 1'b0);
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic end_sim;
		if (n_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	task automatic restart(input logic [4:0] s);
		@(negedge clock);
		reset = 1'b1;
		sw = s;
		repeat (4) @(negedge clock);
		reset = 1'b0;
		repeat (5) @(negedge clock);
	endtask : restart
	task automatic t_factory;
		int k;
		restart(FACTORY_SW);
		check("irq after reset", {12'h0, irq}, 16'h0);
		check("dma after reset", {13'h0, dma}, 16'h0);
		u_iabd_host_model.io(0, 10'h220, 16'hA5C3, 1, 0, 0, q, ho);
		check("ctrl at 220", ctrl, 16'hA5C3);
		check("word width at 220", {15'h0, (n_io16 != 0)}, 16'h1);
		u_iabd_host_model.io(1, 10'h222, 0, 1, 0, 0, q, ho);
		check("status at 222", q, st);
		u_iabd_host_model.io(1, 10'h22C, 0, 1, 0, 0, q, ho);
		check("data at 22C", q, bd);
		u_iabd_host_model.io(1, 10'h23C, 0, 1, 0, 0, q, ho);
		check("idle at 23C", q, RD_IDLE);
		check("data read pulses", 16'(n_dread), 16'h1);
		k = n_io16;
		u_iabd_host_model.io(1, 10'h240, 0, 1, 0, 0, q, ho);
		check("no claim at 240", {15'h0, ho}, 16'h1);
		check("no width at 240", 16'(n_io16 - k), 16'h0);
	endtask : t_factory
	task automatic t_refuse;
		u_iabd_host_model.io(0, 10'h220, 16'h0F0F, 1, 1, 0, q, ho);
		check("ctrl after dma cycle", ctrl, 16'hA5C3);
		u_iabd_host_model.io(0, 10'h220, 16'h0F0F, 1, 0, 1, q, ho);
		check("ctrl after memory write", ctrl, 16'hA5C3);
		u_iabd_host_model.io(0, 10'h200, 16'h0F0F, 1, 0, 0, q, ho);
		check("ctrl after foreign base", ctrl, 16'hA5C3);
	endtask : t_refuse
	task automatic t_strobe;
		u_iabd_host_model.io(0, 10'h228, 16'h0, 1, 0, 0, q, ho);
		check("start pulses", 16'(n_start), 16'h1);
		u_iabd_host_model.io(1, 10'h22A, 0, 1, 0, 0, q, ho);
		check("clear pulses", 16'(n_clear), 16'h1);
		u_iabd_host_model.io(0, 10'h224, 16'h000A, 1, 0, 0, q, ho);
		check("irq select", {12'h0, irq}, 16'h000A);
		u_iabd_host_model.io(0, 10'h226, 16'h0005, 1, 0, 0, q, ho);
		check("dma select", {13'h0, dma}, 16'h0005);
		check("ctrl kept", ctrl, 16'hA5C3);
	endtask : t_strobe
	task automatic t_bases;
		restart(5'h05);
		check("reserved flag", {15'h0, rsv}, 16'h1);
		u_iabd_host_model.io(1, 10'h0A2, 0, 1, 0, 0, q, ho);
		check("reserved no claim", {15'h0, ho}, 16'h1);
		restart(5'h1F);
		u_iabd_host_model.io(1, 10'h3E2, 0, 1, 0, 0, q, ho);
		check("status at 3E2", q, st);
		u_iabd_host_model.io(1, 10'h3E3, 0, 0, 0, 0, q, ho);
		check("high byte at 3E3", {8'h0, q[7:0]}, {8'h0, st[15:8]});
	endtask : t_bases
	initial
	begin
		reset = 1'b1;
		{n_errors, samples_checked, n_start, n_clear, n_dread, n_io16} = '0;
		sw = FACTORY_SW;
		st = 16'h1234;
		bd = 16'hBEEF;
		t_factory();
		t_refuse();
		t_strobe();
		t_bases();
		end_sim();
	end
	initial
	begin
		#100us;
		n_errors++;
		end_sim();
	end
endmodule : iabd_decoder_tb
